// >>> design/scc_cfg.svh
// constants of the serial calendar clock port
`ifndef SCC_CFG_SVH
`define SCC_CFG_SVH

`define SCC_START_WR     8'h5f
`define SCC_START_RD     8'hdf
`define SCC_START_CTL    8'h9f
`define SCC_STOP         8'h1f

`define SCC_TIME_W       56
`define SCC_CTL_W        4
`define SCC_FRAME_W      64
`define SCC_RD_LAST      6'h3f

`define SCC_SEC_LSB      0
`define SCC_MIN_LSB      8
`define SCC_HOUR_LSB     16
`define SCC_WDAY_LSB     24
`define SCC_DATE_LSB     32
`define SCC_MON_LSB      40
`define SCC_YEAR_LSB     48

`define SCC_SEC_MASK     8'h7f
`define SCC_MIN_MASK     8'h7f
`define SCC_HOUR_MASK    8'h3f
`define SCC_WDAY_MASK    8'h07
`define SCC_DATE_MASK    8'h3f
`define SCC_MON_MASK     8'h1f
`define SCC_YEAR_MASK    8'hff

`define SCC_SEC_MAX      8'h59
`define SCC_HOUR_MAX     8'h23
`define SCC_WDAY_MAX     8'h07
`define SCC_MON_MAX      8'h12
`define SCC_YEAR_MAX     8'h99
`define SCC_VAL_ZERO     8'h00
`define SCC_VAL_ONE      8'h01
`define SCC_FEB          8'h02
`define SCC_DAYS_LONG    8'h31
`define SCC_DAYS_SHORT   8'h30
`define SCC_DAYS_FEB     8'h28
`define SCC_DAYS_LEAP    8'h29

`define SCC_CTL_RST      4'h0
`define SCC_CTL_WAKE_EN  0

`define SCC_DIV_LF       32000
`define SCC_DIV_HF       384000
`define SCC_REF_KHZ      32
`define SCC_WAKE_PER_US  720
`define SCC_WAKE_LOW_US  120
`define SCC_WAKE_PER_CYC ((`SCC_WAKE_PER_US * `SCC_REF_KHZ) / 1000)
`define SCC_WAKE_LOW_CYC ((`SCC_WAKE_LOW_US * `SCC_REF_KHZ) / 1000)

`define SCC_FIFO_DEPTH   16
`define SCC_FIFO_WIDTH   1

`endif

// >>> design/scc_fifo.sv
// ready/valid fifo for received serial bits
`timescale 1ns/1ps
module scc_fifo #(
    parameter int unsigned WIDTH = 1,
    parameter int unsigned DEPTH = 16
)(
    input  wire logic             sys_clk_i,  // system clock
    input  wire logic             rstn_i,     // async reset, active low
    input  wire logic [WIDTH-1:0] in_data_i,  // write data
    input  wire logic             in_valid_i, // write request
    output logic                  in_ready_o, // not full
    output logic [WIDTH-1:0]      out_data_o, // head word
    output logic                  out_valid_o,// not empty
    input  wire logic             out_ready_i // consumer takes head
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      rd_q;
    logic             push;
    logic             pop;

    assign in_ready_o  = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
    assign out_valid_o = (wr_q != rd_q);
    assign out_data_o  = mem_q[rd_q[AW-1:0]];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_ff @(posedge sys_clk_i)
    begin
        if (push)
            mem_q[wr_q[AW-1:0]] <= in_data_i;
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            wr_q <= '0;
            rd_q <= '0;
        end
        else
        begin
            if (push)
                wr_q <= wr_q + 1'b1;
            if (pop)
                rd_q <= rd_q + 1'b1;
        end
    end

endmodule : scc_fifo

// >>> design/scc_pkg.sv
// types of the serial calendar clock port
package scc_pkg;

    typedef enum logic [2:0] {
        md_idle    = 3'b000,
        md_wr_time = 3'b001,
        md_wr_ctl  = 3'b010,
        md_rd_arm  = 3'b011,
        md_rd      = 3'b100
    } scc_mode_e;

    typedef logic [7:0] scc_bcd_t;

endpackage : scc_pkg

// >>> design/scc_top.sv
// serial calendar clock: two-wire host port, calendar counters, prescaler, wake-up
// Contract
// - control-only write loads nibble on falling edge of stop code's 8th clock
// - write data bits sampled on rising edge of host clock
// - time-write start code enters write mode; from idle it also halts and clears prescaler
// - time write keeps last 56 bits before stop code
// - time write commits and restarts prescaler on 8th stop clock falling edge
// - all serial transfers are least significant bit first
// - read data shifts out one bit per host clock falling edge
// - read start code turns data pin to output on 8th clock fall
// - read delivers exactly 56 bits copied from running counters
// - device drives stop code itself right after last read bit
// - data pin returns to input on 8th stop clock falling edge
// - seconds or minutes outside 0..59 become 0
// - hours outside 0..23 become 0
// - day of week outside 1..7 becomes 1
// - date beyond month length becomes 1, leap February allows 29
// - month outside 1..12 becomes 1
// - year outside 0..99 becomes 0
// - control nibble stored as written, no correction
// - unused time bits forced to 0
// - any byte matching a start or stop pattern acts as that code
// - prescaler divides reference by 32000 or 384000 for one second
// - start codes 5f time write, df time read, 9f control write
// - stop code 1f, host sends after writes, device after reads
// - control write keeps last 4 bits before stop as nibble
`timescale 1ns/1ps
`include "scc_cfg.svh"
module scc_top #(
    parameter int unsigned PRESCALE_DIV = `SCC_DIV_LF,
    parameter int unsigned WAKE_PER     = `SCC_WAKE_PER_CYC,
    parameter int unsigned WAKE_LOW     = `SCC_WAKE_LOW_CYC,
    parameter int unsigned FIFO_DEPTH   = `SCC_FIFO_DEPTH
)(
    input  wire logic sys_clk_i,    // 200 MHz system clock
    input  wire logic rstn_i,       // async reset, active low
    input  wire logic ref_clk_i,    // reference frequency input pin
    input  wire logic ser_clk_i,    // host shift clock pin
    input  wire logic data_i,       // data pin level in
    output logic      data_o,       // data pin level out
    output logic      data_oe_o,    // data pin driven by device
    output logic      wake_o,       // wake-up pin level out, always low
    output logic      wake_oe_o     // wake-up pin pulled low
);
    localparam int unsigned PW = $clog2(PRESCALE_DIV);
    localparam int unsigned WW = $clog2(WAKE_PER);
    localparam logic [PW-1:0] PRE_LAST = PW'(PRESCALE_DIV - 1);
    localparam logic [WW-1:0] WAKE_LAST = WW'(WAKE_PER - 1);
    localparam logic [WW-1:0] WAKE_LOW_C = WW'(WAKE_LOW);

    // pin synchronisers and edge detect
    logic [2:0] sclk_q;
    logic [1:0] sdat_q;
    logic [2:0] rclk_q;
    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            sclk_q <= 3'h0;
            sdat_q <= 2'h0;
            rclk_q <= 3'h0;
        end
        else
        begin
            sclk_q <= {sclk_q[1:0], ser_clk_i};
            sdat_q <= {sdat_q[0], data_i};
            rclk_q <= {rclk_q[1:0], ref_clk_i};
        end
    end

    logic s_rise;
    logic s_fall;
    logic r_rise;
    assign s_rise = sclk_q[1] && !sclk_q[2];
    assign s_fall = !sclk_q[1] && sclk_q[2];
    assign r_rise = rclk_q[1] && !rclk_q[2];

    scc_pkg::scc_mode_e mode_q;
    logic                  reading;
    assign reading = (mode_q == scc_pkg::md_rd_arm) || (mode_q == scc_pkg::md_rd);

    // sampled bit held until the fifo takes it
    logic smp_v_q;
    logic smp_b_q;
    logic in_ready;
    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            smp_v_q <= 1'b0;
            smp_b_q <= 1'b0;
        end
        else if (s_rise && !reading)
        begin
            smp_v_q <= 1'b1;
            smp_b_q <= sdat_q[1];
        end
        else if (in_ready)
            smp_v_q <= 1'b0;
    end

    logic bit_v;
    logic bit_b;
    logic pend_q;
    logic bit_take;
    assign bit_take = bit_v && !pend_q && !reading;

    scc_fifo #(
        .WIDTH (`SCC_FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .sys_clk_i   (sys_clk_i),
        .rstn_i      (rstn_i),
        .in_data_i   (smp_b_q),
        .in_valid_i  (smp_v_q),
        .in_ready_o  (in_ready),
        .out_data_o  (bit_b),
        .out_valid_o (bit_v),
        .out_ready_i (bit_take)
    );

    // calendar counters
    scc_pkg::scc_bcd_t sec_q, min_q, hour_q, wday_q, date_q, mon_q, year_q;
    logic [3:0]        ctl_q;

    function automatic logic bcd_ok(input logic [7:0] v, input logic [7:0] lo,
                                    input logic [7:0] hi);
        return (v[3:0] <= 4'h9) && (v[7:4] <= 4'h9) && (v >= lo) && (v <= hi);
    endfunction : bcd_ok

    function automatic logic is_leap(input logic [7:0] y);
        if (y[4])
            return (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
        return (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
    endfunction : is_leap

    function automatic logic [7:0] month_len(input logic [7:0] m, input logic [7:0] y);
        unique case (m)
            8'h02:                      return is_leap(y) ? `SCC_DAYS_LEAP : `SCC_DAYS_FEB;
            8'h04, 8'h06, 8'h09, 8'h11: return `SCC_DAYS_SHORT;
            default:                    return `SCC_DAYS_LONG;
        endcase
    endfunction : month_len

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] == 4'h9)
            return {v[7:4] + 4'h1, 4'h0};
        return v + 8'h01;
    endfunction : bcd_inc

    // shift register, newest bit at the top (lsb first framing)
    logic [`SCC_FRAME_W-1:0] sr_q;
    logic [`SCC_FRAME_W-1:0] sr_d;
    logic [7:0]              win_d;
    assign sr_d  = {bit_b, sr_q[`SCC_FRAME_W-1:1]};
    assign win_d = sr_d[`SCC_FRAME_W-1:`SCC_TIME_W];

    // correction of a received time value
    logic [`SCC_TIME_W-1:0] wr_w;
    scc_pkg::scc_bcd_t c_sec, c_min, c_hour, c_wday, c_date, c_mon, c_year;
    always_comb
    begin
        wr_w   = sr_q[`SCC_TIME_W-1:0];
        c_sec  = wr_w[`SCC_SEC_LSB +: 8] & `SCC_SEC_MASK;
        c_min  = wr_w[`SCC_MIN_LSB +: 8] & `SCC_MIN_MASK;
        c_hour = wr_w[`SCC_HOUR_LSB +: 8] & `SCC_HOUR_MASK;
        c_wday = wr_w[`SCC_WDAY_LSB +: 8] & `SCC_WDAY_MASK;
        c_date = wr_w[`SCC_DATE_LSB +: 8] & `SCC_DATE_MASK;
        c_mon  = wr_w[`SCC_MON_LSB +: 8] & `SCC_MON_MASK;
        c_year = wr_w[`SCC_YEAR_LSB +: 8] & `SCC_YEAR_MASK;
        if (!bcd_ok(c_sec, `SCC_VAL_ZERO, `SCC_SEC_MAX))
            c_sec = `SCC_VAL_ZERO;
        if (!bcd_ok(c_min, `SCC_VAL_ZERO, `SCC_SEC_MAX))
            c_min = `SCC_VAL_ZERO;
        if (!bcd_ok(c_hour, `SCC_VAL_ZERO, `SCC_HOUR_MAX))
            c_hour = `SCC_VAL_ZERO;
        if (!bcd_ok(c_wday, `SCC_VAL_ONE, `SCC_WDAY_MAX))
            c_wday = `SCC_VAL_ONE;
        if (!bcd_ok(c_mon, `SCC_VAL_ONE, `SCC_MON_MAX))
            c_mon = `SCC_VAL_ONE;
        if (!bcd_ok(c_year, `SCC_VAL_ZERO, `SCC_YEAR_MAX))
            c_year = `SCC_VAL_ZERO;
        if (!bcd_ok(c_date, `SCC_VAL_ONE, month_len(c_mon, c_year)))
            c_date = `SCC_VAL_ONE;
    end

    // frame decoder
    logic [2:0] bcnt_q;
    logic [5:0] rcnt_q;
    logic       commit_time;
    logic       commit_ctl;
    assign commit_time = s_fall && pend_q && (mode_q == scc_pkg::md_wr_time);
    assign commit_ctl  = s_fall && pend_q && (mode_q == scc_pkg::md_wr_ctl);

    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            mode_q    <= scc_pkg::md_idle;
            sr_q      <= '0;
            bcnt_q    <= 3'h0;
            rcnt_q    <= 6'h0;
            pend_q    <= 1'b0;
            data_o    <= 1'b0;
            data_oe_o <= 1'b0;
        end
        else if (s_fall && pend_q)
        begin
            mode_q <= scc_pkg::md_idle;
            pend_q <= 1'b0;
            sr_q   <= '0;
        end
        else if (s_fall && mode_q == scc_pkg::md_rd_arm)
        begin
            sr_q      <= {`SCC_STOP, year_q, mon_q, date_q, wday_q,
                          hour_q, min_q, sec_q};
            data_o    <= sec_q[0];
            data_oe_o <= 1'b1;
            rcnt_q    <= 6'h0;
            mode_q    <= scc_pkg::md_rd;
        end
        else if (s_fall && mode_q == scc_pkg::md_rd)
        begin
            if (rcnt_q == `SCC_RD_LAST)
            begin
                data_oe_o <= 1'b0;
                data_o    <= 1'b0;
                mode_q    <= scc_pkg::md_idle;
                sr_q      <= '0;
            end
            else
            begin
                sr_q   <= {1'b0, sr_q[`SCC_FRAME_W-1:1]};
                data_o <= sr_q[1];
                rcnt_q <= rcnt_q + 6'h1;
            end
        end
        else if (bit_take)
        begin
            sr_q   <= sr_d;
            bcnt_q <= bcnt_q + 3'h1;
            if (mode_q == scc_pkg::md_idle || bcnt_q == 3'h7)
            begin
                // idle keeps the count at 0; inside a frame 7 wraps to 0 anyway
                bcnt_q <= 3'h0;
                unique case (win_d)
                    `SCC_START_WR:  mode_q <= scc_pkg::md_wr_time;
                    `SCC_START_CTL: mode_q <= scc_pkg::md_wr_ctl;
                    `SCC_START_RD:  mode_q <= scc_pkg::md_rd_arm;
                    `SCC_STOP:      pend_q <= (mode_q != scc_pkg::md_idle);
                    default:        ;
                endcase
            end
        end
    end

    // control nibble
    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            ctl_q <= `SCC_CTL_RST;
        else if (commit_ctl)
            ctl_q <= sr_q[`SCC_TIME_W-1 -: `SCC_CTL_W];
    end

    // one-second prescaler
    logic [PW-1:0] pre_q;
    logic          run_q;
    logic          tick;
    assign tick = run_q && r_rise && (pre_q == PRE_LAST);

    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            pre_q <= '0;
            run_q <= 1'b1;
        end
        else if (bit_take && mode_q == scc_pkg::md_idle && win_d == `SCC_START_WR)
        begin
            pre_q <= '0;
            run_q <= 1'b0;
        end
        else if (commit_time)
        begin
            pre_q <= '0;
            run_q <= 1'b1;
        end
        else if (run_q && r_rise)
            pre_q <= tick ? '0 : pre_q + 1'b1;
    end

    // calendar update; a commit overrides a tick in the same cycle
    logic w_sec, w_min, w_hour, w_date, w_mon;
    assign w_sec  = sec_q == `SCC_SEC_MAX;
    assign w_min  = w_sec && min_q == `SCC_SEC_MAX;
    assign w_hour = w_min && hour_q == `SCC_HOUR_MAX;
    assign w_date = w_hour && date_q == month_len(mon_q, year_q);
    assign w_mon  = w_date && mon_q == `SCC_MON_MAX;

    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            sec_q  <= `SCC_VAL_ZERO;
            min_q  <= `SCC_VAL_ZERO;
            hour_q <= `SCC_VAL_ZERO;
            wday_q <= `SCC_VAL_ONE;
            date_q <= `SCC_VAL_ONE;
            mon_q  <= `SCC_VAL_ONE;
            year_q <= `SCC_VAL_ZERO;
        end
        else if (commit_time)
        begin
            sec_q  <= c_sec;
            min_q  <= c_min;
            hour_q <= c_hour;
            wday_q <= c_wday;
            date_q <= c_date;
            mon_q  <= c_mon;
            year_q <= c_year;
        end
        else if (tick)
        begin
            sec_q <= w_sec ? `SCC_VAL_ZERO : bcd_inc(sec_q);
            if (w_sec)
                min_q <= w_min ? `SCC_VAL_ZERO : bcd_inc(min_q);
            if (w_min)
                hour_q <= w_hour ? `SCC_VAL_ZERO : bcd_inc(hour_q);
            if (w_hour)
            begin
                wday_q <= (wday_q == `SCC_WDAY_MAX) ? `SCC_VAL_ONE : bcd_inc(wday_q);
                date_q <= w_date ? `SCC_VAL_ONE : bcd_inc(date_q);
            end
            if (w_date)
                mon_q <= w_mon ? `SCC_VAL_ONE : bcd_inc(mon_q);
            if (w_mon)
                year_q <= (year_q == `SCC_YEAR_MAX) ? `SCC_VAL_ZERO : bcd_inc(year_q);
        end
    end

    // wake-up pulse from the reference input
    logic [WW-1:0] wcnt_q;
    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            wcnt_q    <= '0;
            wake_oe_o <= 1'b0;
            wake_o    <= 1'b0;
        end
        else
        begin
            if (r_rise)
                wcnt_q <= (wcnt_q == WAKE_LAST) ? '0 : wcnt_q + 1'b1;
            wake_oe_o <= ctl_q[`SCC_CTL_WAKE_EN] && (wcnt_q < WAKE_LOW_C);
            wake_o    <= 1'b0;
        end
    end

endmodule : scc_top

// >>> test/scc_host_model.sv
// host model: drives the shift clock and the data pin, resolves the pin level
`timescale 1ns/1ps
module scc_host_model #(
    parameter int HALF = 22
)(
    input  wire logic sys_clk_i,  // pacing clock
    input  wire logic dev_oe_i,   // device drives data
    input  wire logic dev_d_i,    // device data level
    output logic      ser_clk_o,  // shift clock
    output logic      line_o      // resolved data pin
);
    logic host_oe_q = 1'b0;
    logic host_d_q  = 1'b0;
    // pull-down takes a released pin low
    assign line_o = dev_oe_i ? dev_d_i : (host_oe_q ? host_d_q : 1'b0);
    initial ser_clk_o = 1'b0;

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask : wait_cyc

    task automatic clk_bit(input logic b, output logic r);
        host_d_q = b;
        wait_cyc(HALF);
        r = line_o;
        ser_clk_o = 1'b1;
        wait_cyc(HALF);
        ser_clk_o = 1'b0;
    endtask : clk_bit

    task automatic put_byte(input logic [7:0] v);
        logic r;
        host_oe_q = 1'b1;
        for (int i = 0; i < 8; i++) clk_bit(v[i], r);
    endtask : put_byte

    task automatic put_time(input logic [55:0] v);
        logic r;
        host_oe_q = 1'b1;
        for (int i = 0; i < 56; i++) clk_bit(v[i], r);
    endtask : put_time

    task automatic end_frame();
        host_oe_q = 1'b0;
        host_d_q = 1'b0;
        wait_cyc(8);
    endtask : end_frame

    task automatic get_time(output logic [55:0] t, output logic [7:0] s);
        put_byte(8'hdf);
        host_oe_q = 1'b0;
        for (int i = 0; i < 56; i++) clk_bit(1'b0, t[i]);
        for (int i = 0; i < 8; i++) clk_bit(1'b0, s[i]);
        wait_cyc(8);
    endtask : get_time
endmodule : scc_host_model

// >>> test/scc_top_properties.sv
// pin-level assertions for the serial calendar clock port
`timescale 1ns/1ps
`include "scc_cfg.svh"
module scc_top_properties #(
    parameter int unsigned PRESCALE_DIV = 8,
    parameter int unsigned WAKE_PER     = 8,
    parameter int unsigned WAKE_LOW     = 2,
    parameter int unsigned FIFO_DEPTH   = 16
)(
    input wire logic sys_clk_i,  // system clock
    input wire logic rstn_i,     // async reset, active low
    input wire logic ref_clk_i,  // reference pin
    input wire logic ser_clk_i,  // host shift clock
    input wire logic data_i,     // data pin level
    input wire logic data_o,     // device data level
    input wire logic data_oe_o,  // device drives data
    input wire logic wake_o,     // wake level
    input wire logic wake_oe_o   // wake pulled low
);
    logic        ser_q;
    logic        ref_q;
    logic        oe_q;
    logic        wake_q;
    logic        seen_q;
    logic [6:0]  fall_cnt_q;
    logic [15:0] low_cnt_q;
    logic [15:0] per_cnt_q;
    logic [7:0]  stop_v;
    wire         ser_fall = ser_q & ~ser_clk_i;
    wire         ref_rise = ~ref_q & ref_clk_i;
    assign stop_v = `SCC_STOP;

    always_ff @(posedge sys_clk_i or negedge rstn_i)
        if (!rstn_i)
        begin
            ser_q  <= 1'b0;
            ref_q  <= 1'b0;
            oe_q   <= 1'b0;
            wake_q <= 1'b0;
            seen_q <= 1'b0;
        end
        else
        begin
            ser_q  <= ser_clk_i;
            ref_q  <= ref_clk_i;
            oe_q   <= data_oe_o;
            wake_q <= wake_oe_o;
            seen_q <= seen_q | (wake_oe_o & ~wake_q);
        end

    // falls of the shift clock seen while the device drives the pin
    always_ff @(posedge sys_clk_i or negedge rstn_i)
        if (!rstn_i) fall_cnt_q <= 7'h0;
        else if (data_oe_o && !oe_q) fall_cnt_q <= 7'h0;
        else if (data_oe_o && ser_fall) fall_cnt_q <= fall_cnt_q + 7'h1;

    always_ff @(posedge sys_clk_i or negedge rstn_i)
        if (!rstn_i) low_cnt_q <= 16'h0;
        else if (wake_oe_o && !wake_q) low_cnt_q <= 16'h0;
        else if (wake_oe_o && ref_rise) low_cnt_q <= low_cnt_q + 16'h1;

    always_ff @(posedge sys_clk_i or negedge rstn_i)
        if (!rstn_i) per_cnt_q <= 16'h0;
        else if (wake_oe_o && !wake_q) per_cnt_q <= 16'h0;
        else if (ref_rise) per_cnt_q <= per_cnt_q + 16'h1;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);

    property p_wake_level; wake_o == 1'b0; endproperty
    a_wake_level: assert property (p_wake_level) else $error("wake level high");
    property p_oe_on; $rose(data_oe_o) |-> !ser_clk_i && $past(ser_clk_i, 8); endproperty
    a_oe_on: assert property (p_oe_on) else $error("drive began off a fall");
    property p_oe_hold; $rose(data_oe_o) |=> data_oe_o [*8]; endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("drive dropped early");
    property p_oe_off; $fell(data_oe_o) |-> !ser_clk_i && $past(ser_clk_i, 8); endproperty
    a_oe_off: assert property (p_oe_off) else $error("drive ended off a fall");
    property p_data_hold;
        data_oe_o && $past(data_oe_o) && ser_clk_i |-> $stable(data_o);
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("data moved while clock high");
    property p_bit_count; $fell(data_oe_o) |-> fall_cnt_q == 7'h40; endproperty
    a_bit_count: assert property (p_bit_count) else $error("read length wrong");
    property p_stop_bits;
        data_oe_o && ser_clk_i && fall_cnt_q >= 7'h38 |-> data_o == stop_v[fall_cnt_q[2:0]];
    endproperty
    a_stop_bits: assert property (p_stop_bits) else $error("stop code wrong");
    property p_wake_width; $fell(wake_oe_o) |-> low_cnt_q == 16'(WAKE_LOW); endproperty
    a_wake_width: assert property (p_wake_width) else $error("wake width wrong");
    property p_wake_period;
        $rose(wake_oe_o) && seen_q |-> per_cnt_q == 16'(WAKE_PER);
    endproperty
    a_wake_period: assert property (p_wake_period) else $error("wake period wrong");

    c_read: cover property ($fell(data_oe_o));
    c_stop: cover property (data_oe_o && fall_cnt_q == 7'h3f);
    c_wake: cover property ($fell(wake_oe_o));
endmodule : scc_top_properties

bind scc_top scc_top_properties #(
    .PRESCALE_DIV(PRESCALE_DIV),
    .WAKE_PER    (WAKE_PER),
    .WAKE_LOW    (WAKE_LOW),
    .FIFO_DEPTH  (FIFO_DEPTH)
) scc_top_properties_i (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .ref_clk_i(ref_clk_i),
    .ser_clk_i(ser_clk_i), .data_i(data_i), .data_o(data_o), .data_oe_o(data_oe_o),
    .wake_o(wake_o), .wake_oe_o(wake_oe_o));

// >>> test/scc_top_tb.sv
// self-checking bench for the serial calendar clock port
`timescale 1ns/1ps
`include "scc_cfg.svh"
module scc_top_tb;
    localparam int PDIV = 8;
    logic        sys_clk;
    logic        rstn;
    logic        ref_clk;
    logic        ser_clk;
    logic        line;
    logic        dout;
    logic        doe;
    logic        wake;
    logic        wake_oe;
    int          failures;
    int          n_checks;
    int          hi;
    int          wake_hi_n = 0;
    logic [55:0] model_time;
    logic [55:0] rd_t;
    logic [7:0]  rd_s;
    logic [55:0] dir_q[$];

    scc_top #(.PRESCALE_DIV(PDIV), .WAKE_PER(8), .WAKE_LOW(2)) scc_top_i (
        .sys_clk_i(sys_clk), .rstn_i(rstn), .ref_clk_i(ref_clk), .ser_clk_i(ser_clk),
        .data_i(line), .data_o(dout), .data_oe_o(doe), .wake_o(wake), .wake_oe_o(wake_oe));
    scc_host_model scc_host_model_i (.sys_clk_i(sys_clk), .dev_oe_i(doe),
        .dev_d_i(dout), .ser_clk_o(ser_clk), .line_o(line));

    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    always @(negedge sys_clk) if (wake_oe === 1'b1) wake_hi_n++;

    task automatic chk(input logic [55:0] seen, input logic [55:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic report_and_stop();
        $display("TB: %0d checks, %0d mismatches", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : report_and_stop

    function automatic int b2i(input logic [7:0] v);
        return v[7:4] * 10 + v[3:0];
    endfunction : b2i
    function automatic logic [7:0] i2b(input int v);
        return {4'(v / 10), 4'(v % 10)};
    endfunction : i2b

    // reference correction of a written time word
    function automatic logic [55:0] fix(input logic [55:0] w);
        int s, m, h, d, dt, mo, y, lim;
        s = b2i(w[7:0] & 8'h7f);
        m = b2i(w[15:8] & 8'h7f);
        h = b2i(w[23:16] & 8'h3f);
        d = b2i(w[31:24] & 8'h07);
        dt = b2i(w[39:32] & 8'h3f);
        mo = b2i(w[47:40] & 8'h1f);
        y = b2i(w[55:48]);
        if (s > 59) s = 0;
        if (m > 59) m = 0;
        if (h > 23) h = 0;
        if (d < 1 || d > 7) d = 1;
        if (mo < 1 || mo > 12) mo = 1;
        if (y > 99) y = 0;
        lim = (mo == 2) ? ((y % 4 == 0) ? 29 : 28) : ((mo inside {4, 6, 9, 11}) ? 30 : 31);
        if (dt < 1 || dt > lim) dt = 1;
        return {i2b(y), i2b(mo), i2b(dt), i2b(d), i2b(h), i2b(m), i2b(s)};
    endfunction : fix

    function automatic logic [55:0] rnd_time();
        logic [55:0] t;
        for (int i = 0; i < 7; i++) t[i*8+:8] = {4'($urandom % 10), 4'($urandom % 10)};
        return t;
    endfunction : rnd_time

    task automatic wr_time(input logic [55:0] t);
        scc_host_model_i.put_byte(`SCC_START_WR);
        scc_host_model_i.put_byte(8'($urandom % 31));
        scc_host_model_i.put_time(t);
        scc_host_model_i.put_byte(`SCC_STOP);
        scc_host_model_i.end_frame();
        model_time = fix(t);
    endtask : wr_time

    task automatic rd_check();
        scc_host_model_i.get_time(rd_t, rd_s);
        chk(rd_t, model_time);
        chk(56'(rd_s), 56'(`SCC_STOP));
        chk(56'(doe), 56'h0);
    endtask : rd_check

    task automatic ref_pulses(input int n, output int h);
        h = 0;
        repeat (n)
        begin
            repeat (10) @(posedge sys_clk);
            #1 ref_clk = 1'b1;
            repeat (10) @(posedge sys_clk);
            #1 ref_clk = 1'b0;
            h += int'(wake_oe === 1'b1);
        end
    endtask : ref_pulses

    initial
    begin
        repeat (90000) @(posedge sys_clk);
        failures++;
        report_and_stop();
    end

    initial
    begin
        rstn = 1'b0;
        ref_clk = 1'b0;
        failures = 0;
        n_checks = 0;
        dir_q = '{56'h24_02_29_02_23_59_59, 56'h23_02_29_07_00_00_00,
                  56'h98_04_31_00_24_60_d8, 56'h99_11_31_05_12_34_56};
        void'($urandom(32'ha12cea9b));
        repeat (12) @(posedge sys_clk);
        #1 rstn = 1'b1;
        scc_host_model_i.wait_cyc(4);
        for (int k = 0; k < 3; k++)
        begin
            wr_time(rnd_time());
            rd_check();
        end
        $display("TB: random writes done");
        foreach (dir_q[k])
        begin
            wr_time(dir_q[k]);
            rd_check();
        end
        $display("TB: corrections done");
        scc_host_model_i.put_byte(`SCC_START_WR);
        scc_host_model_i.put_time(rnd_time());
        scc_host_model_i.put_byte(`SCC_START_CTL);
        scc_host_model_i.put_byte(8'he0);
        scc_host_model_i.put_byte(`SCC_STOP);
        scc_host_model_i.end_frame();
        rd_check();
        $display("TB: code restart done");
        fork
            wr_time(56'h99_12_31_03_23_59_59);
            begin
                repeat (600) @(posedge sys_clk);
                ref_pulses(20, hi);
            end
        join
        ref_pulses(PDIV - 1, hi);
        rd_check();
        ref_pulses(1, hi);
        model_time = 56'h00_01_01_04_00_00_00;
        rd_check();
        chk(56'(wake_hi_n), 56'h0);
        $display("TB: prescaler done");
        scc_host_model_i.put_byte(`SCC_START_CTL);
        scc_host_model_i.put_byte(8'h30);
        scc_host_model_i.put_byte(`SCC_STOP);
        scc_host_model_i.end_frame();
        ref_pulses(8, hi);
        ref_pulses(24, hi);
        chk(56'(hi), 56'h6);
        $display("TB: wake done");
        report_and_stop();
    end
endmodule : scc_top_tb
